/* qec_pkg.sv */
// constants and types shared by the quadrature encoder counter
package qec_pkg;
    localparam int unsigned NUM_CHAN         = 3;
    localparam int unsigned MAX_CHAN         = 8;
    localparam int unsigned ADDR_W           = 8;
    localparam int unsigned DATA_W           = 32;
    localparam int unsigned FRAC_BITS        = 8;
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned SAMPLE_PERIOD_NS = 1000;
    localparam int unsigned SAMPLE_DIV       = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CAP_SHIFT        = 4;
    localparam int unsigned CAP_SAMPLES      = 1 << CAP_SHIFT;
    localparam int unsigned INC_SHIFT        = FRAC_BITS - CAP_SHIFT;
    localparam logic [3:0]  SAMPLE_DIV_LAST  = 4'(SAMPLE_DIV - 1);
    localparam logic [3:0]  CAP_LAST         = 4'(CAP_SAMPLES - 1);
    localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h00;
    localparam logic [7:0]  OFF_IRQ_CLEAR    = 8'h04;
    localparam logic [7:0]  OFF_IRQ_ENABLE   = 8'h08;
    localparam logic [2:0]  CHAN_BLOCK_FIRST = 3'h1;
    localparam logic [4:0]  OFF_CTRL         = 5'h00;
    localparam logic [4:0]  OFF_SCALE        = 5'h04;
    localparam logic [4:0]  OFF_FLOOR        = 5'h08;
    localparam logic [4:0]  OFF_COUNT        = 5'h0c;
    localparam logic [4:0]  OFF_RAW          = 5'h10;
    localparam logic [4:0]  OFF_POSITION     = 5'h14;
    localparam logic [4:0]  OFF_VELOCITY     = 5'h18;
    localparam logic [4:0]  OFF_INTERP       = 5'h1c;
    localparam int unsigned CTRL_SINGLE_BIT  = 0;
    localparam int unsigned CTRL_EVERY_BIT   = 1;
    localparam int unsigned CTRL_ARM_BIT     = 2;
    localparam int unsigned CTRL_RESET_BIT   = 3;
    localparam logic        SINGLE_RESET     = 1'b0;
    localparam logic        EVERY_RESET      = 1'b1;
    localparam logic [15:0] SCALE_RESET      = 16'h0001;
    localparam logic [15:0] FLOOR_RESET      = 16'h0000;
    typedef enum logic [1:0] {
        QEC_MODE_X4     = 2'b00,
        QEC_MODE_X1     = 2'b01,
        QEC_MODE_SINGLE = 2'b11
    } qec_mode_t;
endpackage : qec_pkg

/* qec_counter.sv */
// multi-channel quadrature encoder counter with register port and interrupt
`timescale 1ns/10ps
module qec_counter
    import qec_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic [NUM_CHAN-1:0] enc_a,
    input  wire logic [NUM_CHAN-1:0] enc_b,
    input  wire logic [NUM_CHAN-1:0] enc_z,
    output logic                     irq
);

    // one step of the decoder: -1, 0 or +1
    function automatic logic signed [1:0] qec_step(
        input qec_mode_t  mode,
        input logic [1:0] prev_ab,
        input logic [1:0] cur_ab
    );
        logic one_change;
        logic up;
        one_change = (prev_ab[1] ^ cur_ab[1]) ^ (prev_ab[0] ^ cur_ab[0]);
        up         = cur_ab[1] ^ prev_ab[0];
        qec_step   = 2'sd0;
        case (mode)
            QEC_MODE_SINGLE: begin
                if (cur_ab[1] && !prev_ab[1]) begin
                    qec_step = 2'sd1;
                end
            end
            QEC_MODE_X4: begin
                if (one_change) begin
                    qec_step = up ? 2'sd1 : -2'sd1;
                end
            end
            QEC_MODE_X1: begin
                // count only on A edges with B low, so reversal stays exact
                if (prev_ab == 2'b00 && cur_ab == 2'b10) begin
                    qec_step = 2'sd1;
                end else if (prev_ab == 2'b10 && cur_ab == 2'b00) begin
                    qec_step = -2'sd1;
                end
            end
            default: begin
                qec_step = 2'sd0;
            end
        endcase
    endfunction : qec_step

    function automatic logic signed [39:0] fix_of(input logic signed [31:0] c);
        fix_of = 40'(c) <<< FRAC_BITS;
    endfunction : fix_of

    // a zero scale would divide by zero, so it reads as zero instead
    function automatic logic signed [31:0] scale_div(
        input logic signed [39:0] num,
        input logic        [15:0] sc
    );
        logic signed [39:0] q;
        q = 40'sd0;
        if (sc != 16'h0000) begin
            q = num / $signed({24'h000000, sc});
        end
        scale_div = q[31:0];
    endfunction : scale_div

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        abs32 = v[31] ? 32'(-v) : 32'(v);
    endfunction : abs32

    function automatic logic chan_hit(input logic [ADDR_W-1:0] a, input int unsigned ch);
        chan_hit = (a[7:5] == 3'(ch) + CHAN_BLOCK_FIRST);
    endfunction : chan_hit

    logic        [3:0]  div_cnt;
    logic        [3:0]  cap_cnt;
    logic               sample_tick;
    logic               capture_tick;
    logic               single_sel     [NUM_CHAN];
    logic               every_edge     [NUM_CHAN];
    logic               index_arm      [NUM_CHAN];
    logic               count_reset    [NUM_CHAN];
    logic        [15:0] scale          [NUM_CHAN];
    logic        [15:0] vel_floor      [NUM_CHAN];
    logic        [1:0]  ab_prev        [NUM_CHAN];
    logic               z_prev         [NUM_CHAN];
    logic signed [31:0] count          [NUM_CHAN];
    logic signed [31:0] raw_count      [NUM_CHAN];
    logic signed [31:0] cap_count      [NUM_CHAN];
    logic signed [31:0] vel_delta      [NUM_CHAN];
    logic signed [31:0] position       [NUM_CHAN];
    logic signed [31:0] velocity       [NUM_CHAN];
    logic signed [31:0] interp_pos     [NUM_CHAN];
    logic signed [39:0] interp_fix     [NUM_CHAN];
    logic signed [1:0]  step           [NUM_CHAN];
    logic               index_hit      [NUM_CHAN];
    logic               ctrl_write     [NUM_CHAN];
    logic signed [31:0] next_count     [NUM_CHAN];
    logic signed [31:0] next_delta     [NUM_CHAN];
    logic signed [31:0] next_vel       [NUM_CHAN];
    logic               below_floor    [NUM_CHAN];
    logic signed [39:0] next_interp    [NUM_CHAN];
    logic [NUM_CHAN-1:0] irq_status;
    logic [NUM_CHAN-1:0] irq_enable;
    logic [NUM_CHAN-1:0] irq_event;
    logic [DATA_W-1:0]   next_rdata;

    // sample and capture tick dividers, shared by every channel
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_cnt <= 4'h0;
        end else if (div_cnt == SAMPLE_DIV_LAST) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    assign sample_tick  = (div_cnt == SAMPLE_DIV_LAST);
    assign capture_tick = sample_tick && (cap_cnt == CAP_LAST);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cap_cnt <= 4'h0;
        end else if (sample_tick) begin
            cap_cnt <= cap_cnt + 4'h1;
        end
    end

    // per-channel decode and next values
    always_comb begin
        qec_mode_t          mode;
        logic signed [39:0] cand;
        logic signed [39:0] base;
        mode = QEC_MODE_X4;
        cand = 40'sd0;
        base = 40'sd0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (single_sel[i]) begin
                mode = QEC_MODE_SINGLE;
            end else if (every_edge[i]) begin
                mode = QEC_MODE_X4;
            end else begin
                mode = QEC_MODE_X1;
            end
            step[i]       = sample_tick ? qec_step(mode, ab_prev[i], {enc_a[i], enc_b[i]}) : 2'sd0;
            index_hit[i]  = sample_tick && index_arm[i] && enc_z[i] && !z_prev[i];
            ctrl_write[i] = reg_write && chan_hit(reg_addr, i) && (reg_addr[4:0] == OFF_CTRL);
            if (count_reset[i]) begin
                next_count[i] = 32'sd0;
            end else if (index_hit[i]) begin
                next_count[i] = 32'sd0;
            end else begin
                next_count[i] = count[i] + 32'(step[i]);
            end
            next_delta[i]  = count[i] - cap_count[i];
            next_vel[i]    = scale_div(fix_of(next_delta[i]), scale[i]);
            below_floor[i] = abs32(next_vel[i]) < {16'h0000, vel_floor[i]};
            base = fix_of(next_count[i]);
            cand = interp_fix[i] + (40'(vel_delta[i]) <<< INC_SHIFT);
            if (step[i] != 2'sd0 || vel_delta[i] == 32'sd0 || count_reset[i] || index_hit[i]) begin
                next_interp[i] = base;
            end else if (cand > base + 40'sd255) begin
                next_interp[i] = base + 40'sd255;
            end else if (cand < base - 40'sd255) begin
                next_interp[i] = base - 40'sd255;
            end else begin
                next_interp[i] = cand;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                ab_prev[i] <= 2'b00;
                z_prev[i]  <= 1'b0;
            end
        end else if (sample_tick) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                ab_prev[i] <= {enc_a[i], enc_b[i]};
                z_prev[i]  <= enc_z[i];
            end
        end
    end

    // control and configuration, written by software
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                single_sel[i]  <= SINGLE_RESET;
                every_edge[i]  <= EVERY_RESET;
                index_arm[i]   <= 1'b0;
                count_reset[i] <= 1'b0;
                scale[i]       <= SCALE_RESET;
                vel_floor[i]   <= FLOOR_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (ctrl_write[i]) begin
                    single_sel[i]  <= reg_wdata[CTRL_SINGLE_BIT];
                    every_edge[i]  <= reg_wdata[CTRL_EVERY_BIT];
                    index_arm[i]   <= reg_wdata[CTRL_ARM_BIT];
                    count_reset[i] <= reg_wdata[CTRL_RESET_BIT];
                end else if (index_hit[i]) begin
                    index_arm[i] <= 1'b0;
                end
                if (reg_write && chan_hit(reg_addr, i) && reg_addr[4:0] == OFF_SCALE) begin
                    scale[i] <= reg_wdata[15:0];
                end
                if (reg_write && chan_hit(reg_addr, i) && reg_addr[4:0] == OFF_FLOOR) begin
                    vel_floor[i] <= reg_wdata[15:0];
                end
            end
        end
    end

    // counts, both zeroable and raw
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                count[i]     <= 32'sd0;
                raw_count[i] <= 32'sd0;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                count[i]     <= next_count[i];
                raw_count[i] <= raw_count[i] + 32'(step[i]);
            end
        end
    end

    // capture: scaled position and velocity on the slow tick
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                position[i]  <= 32'sd0;
                velocity[i]  <= 32'sd0;
                cap_count[i] <= 32'sd0;
                vel_delta[i] <= 32'sd0;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (count_reset[i] || index_hit[i]) begin
                    // zeroing would look like a huge jump, so the baseline follows
                    position[i]  <= 32'sd0;
                    cap_count[i] <= 32'sd0;
                end else if (capture_tick) begin
                    position[i]  <= scale_div(fix_of(count[i]), scale[i]);
                    cap_count[i] <= count[i];
                end
                if (capture_tick) begin
                    velocity[i]  <= below_floor[i] ? 32'sd0 : next_vel[i];
                    vel_delta[i] <= below_floor[i] ? 32'sd0 : next_delta[i];
                end
            end
        end
    end

    // interpolated position, refreshed every sample tick
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                interp_fix[i] <= 40'sd0;
                interp_pos[i] <= 32'sd0;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (count_reset[i] || index_hit[i]) begin
                    interp_fix[i] <= 40'sd0;
                    interp_pos[i] <= 32'sd0;
                end else if (sample_tick) begin
                    interp_fix[i] <= next_interp[i];
                    interp_pos[i] <= scale_div(interp_fix[i], scale[i]);
                end
            end
        end
    end

    // index events: set wins over a clear in the same cycle
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            irq_event[i] = index_hit[i];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_status <= '0;
        end else if (reg_write && reg_addr == OFF_IRQ_CLEAR) begin
            irq_status <= (irq_status & ~reg_wdata[NUM_CHAN-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_enable <= '0;
        end else if (reg_write && reg_addr == OFF_IRQ_ENABLE) begin
            irq_enable <= reg_wdata[NUM_CHAN-1:0];
        end
    end

    assign irq = |(irq_status & irq_enable);

    // read mux; unmapped and write-only addresses read as zero
    always_comb begin
        next_rdata = '0;
        if (reg_addr == OFF_IRQ_STATUS) begin
            next_rdata = 32'(irq_status);
        end else if (reg_addr == OFF_IRQ_ENABLE) begin
            next_rdata = 32'(irq_enable);
        end
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (chan_hit(reg_addr, i)) begin
                case (reg_addr[4:0])
                    OFF_CTRL: begin
                        next_rdata = {28'h0000000, count_reset[i], index_arm[i], every_edge[i], single_sel[i]};
                    end
                    OFF_SCALE: begin
                        next_rdata = {16'h0000, scale[i]};
                    end
                    OFF_FLOOR: begin
                        next_rdata = {16'h0000, vel_floor[i]};
                    end
                    OFF_COUNT: begin
                        next_rdata = count[i];
                    end
                    OFF_RAW: begin
                        next_rdata = raw_count[i];
                    end
                    OFF_POSITION: begin
                        next_rdata = position[i];
                    end
                    OFF_VELOCITY: begin
                        next_rdata = velocity[i];
                    end
                    OFF_INTERP: begin
                        next_rdata = interp_pos[i];
                    end
                    default: begin
                        next_rdata = '0;
                    end
                endcase
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : qec_counter

/* qec_counter_sva.sv */
// concurrent checks on the encoder counter ports
`timescale 1ns/10ps
module qec_counter_chk
    import qec_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                reset,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_write,
    input wire logic                reg_read,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic [NUM_CHAN-1:0] enc_a,
    input wire logic [NUM_CHAN-1:0] enc_b,
    input wire logic [NUM_CHAN-1:0] enc_z,
    input wire logic                irq
);
    logic [DATA_W-1:0] wd1;
    logic [DATA_W-1:0] wd2;
    // write data two cycles back, for write-then-read sequences
    always_ff @(posedge sys_clk) begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence wr_at(logic [7:0] a);
        reg_write && reg_addr == a;
    endsequence
    sequence rd_at(logic [7:0] a);
        reg_read && reg_addr == a;
    endsequence
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data not zero outside answer cycle");
    clear_reads_a: assert property (rd_at(OFF_IRQ_CLEAR) |=> reg_rdata == '0)
        else $error("clear register read not zero");
    hole_zero_a: assert property (rd_at(8'h0c) |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    absent_chan_a: assert property (reg_read && reg_addr >= 8'h80 |=> reg_rdata == '0)
        else $error("absent channel read not zero");
    status_width_a: assert property (rd_at(OFF_IRQ_STATUS) |=> reg_rdata[DATA_W-1:NUM_CHAN] == '0)
        else $error("status bits above channel count set");
    irq_masked_a: assert property (reg_write && reg_addr == OFF_IRQ_ENABLE && reg_wdata == '0 |=> !irq)
        else $error("interrupt high with all sources masked");
    mode_back_a: assert property (wr_at(8'h20) ##1 rd_at(8'h20) |=> reg_rdata[1:0] == wd2[1:0])
        else $error("mode bits not read back");
    scale_back_a: assert property (wr_at(8'h24) ##1 rd_at(8'h24) |=> reg_rdata == {16'h0, wd2[15:0]})
        else $error("scale not read back");
    // the reset bit is a register, so the count is zero from the second edge on
    hold_zero_a: assert property (wr_at(8'h20) ##0 reg_wdata[3] ##2 rd_at(8'h2c) |=> reg_rdata == '0)
        else $error("count not held at zero");
endmodule : qec_counter_chk

bind qec_counter qec_counter_chk qec_counter_chk_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .enc_a(enc_a),
    .enc_b(enc_b), .enc_z(enc_z), .irq(irq));

/* qec_enc_model.sv */
// behavioural incremental encoder with index, one per channel
`timescale 1ns/10ps
module qec_enc_model
    import qec_pkg::*;
#(
    parameter int HOLD = 25
)
(
    input  wire logic                sys_clk,
    output logic      [NUM_CHAN-1:0] enc_a,
    output logic      [NUM_CHAN-1:0] enc_b,
    output logic      [NUM_CHAN-1:0] enc_z
);
    logic [1:0] ph [NUM_CHAN];
    initial begin
        enc_a = '0;
        enc_b = '0;
        enc_z = '0;
        foreach (ph[i]) ph[i] = 2'h0;
    end
    // state held over two sample ticks, so no edge is lost
    task automatic put(input int ch);
        @(posedge sys_clk);
        enc_a[ch] <= ph[ch][0] ^ ph[ch][1];
        enc_b[ch] <= ph[ch][1];
        repeat (HOLD) @(posedge sys_clk);
    endtask : put
    // positive n: a leads b
    task automatic step(input int ch, input int n);
        for (int i = 0; i < (n > 0 ? n : -n); i++) begin
            ph[ch] = ph[ch] + (n > 0 ? 2'h1 : 2'h3);
            put(ch);
        end
    endtask : step
    // both phases flip at once, a fault the counter must ignore
    task automatic jump(input int ch);
        ph[ch] = ph[ch] + 2'h2;
        put(ch);
    endtask : jump
    task automatic index(input int ch);
        @(posedge sys_clk);
        enc_z[ch] <= 1'b1;
        repeat (HOLD) @(posedge sys_clk);
        enc_z[ch] <= 1'b0;
        repeat (HOLD) @(posedge sys_clk);
    endtask : index
endmodule : qec_enc_model

/* qec_tb.sv */
// self-checking bench for the encoder counter
`timescale 1ns/10ps
module tb;
    import qec_pkg::*;
    logic                sys_clk;
    logic                reset;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata;
    logic                reg_write;
    logic                reg_read;
    logic [DATA_W-1:0]   reg_rdata;
    logic [NUM_CHAN-1:0] enc_a;
    logic [NUM_CHAN-1:0] enc_b;
    logic [NUM_CHAN-1:0] enc_z;
    logic                irq;
    logic [DATA_W-1:0]   q;
    int                  errors = 0;
    int                  checks_done = 0;
    qec_counter qec_counter_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .enc_a(enc_a), .enc_b(enc_b),
        .enc_z(enc_z), .irq(irq));
    qec_enc_model qec_enc_model_inst (.sys_clk(sys_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask : rc
    // write then read with no gap between the strobes
    task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [7:0] ra);
        wr(a, d);
        reg_addr <= ra;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 q = reg_rdata;
    endtask : wrd
    task automatic ci(input logic e);
        #1 chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : ci
    task automatic t_reset;
        for (int i = 1; i < 4; i++) begin
            rc("ctrl", 8'(32 * i), (i < 4) ? 32'h2 : 32'h0);
            rc("scale", 8'(32 * i + 4), 32'h1);
        end
        rc("floor", 8'h28, 32'h0);
        rc("status", OFF_IRQ_STATUS, 32'h0);
        rc("clear", OFF_IRQ_CLEAR, 32'h0);
        rc("hole", 8'h0c, 32'h0);
        rc("chan3", 8'h80, 32'h0);
        $display("reset values test done");
    endtask : t_reset
    task automatic t_modes;
        wrd(8'h20, 32'h2, 8'h20);
        chk("ctrl", 32'h2, q);
        qec_enc_model_inst.step(0, 6);
        rc("count", 8'h2c, 32'h6);
        qec_enc_model_inst.step(0, -2);
        rc("count", 8'h2c, 32'h4);
        qec_enc_model_inst.jump(0);
        rc("count", 8'h2c, 32'h4);
        rc("raw", 8'h30, 32'h4);
        wr(8'h40, 32'h0);
        qec_enc_model_inst.step(1, 8);
        rc("count", 8'h4c, 32'h2);
        qec_enc_model_inst.step(1, -4);
        rc("count", 8'h4c, 32'h1);
        wr(8'h60, 32'h1);
        qec_enc_model_inst.step(2, 4);
        rc("count", 8'h6c, 32'h1);
        wr(8'h60, 32'h3);
        qec_enc_model_inst.step(2, 4);
        rc("count", 8'h6c, 32'h2);
        $display("count modes test done");
    endtask : t_modes
    task automatic t_index;
        wr(OFF_IRQ_ENABLE, 32'h1);
        qec_enc_model_inst.index(0);
        rc("count", 8'h2c, 32'h4);
        rc("status", OFF_IRQ_STATUS, 32'h0);
        wr(8'h20, 32'h6);
        qec_enc_model_inst.index(0);
        rc("count", 8'h2c, 32'h0);
        rc("position", 8'h34, 32'h0);
        rc("ctrl", 8'h20, 32'h2);
        rc("raw", 8'h30, 32'h4);
        rc("status", OFF_IRQ_STATUS, 32'h1);
        ci(1'b1);
        wr(OFF_IRQ_ENABLE, 32'h0);
        ci(1'b0);
        wr(OFF_IRQ_ENABLE, 32'h1);
        ci(1'b1);
        wr(OFF_IRQ_CLEAR, 32'h1);
        ci(1'b0);
        rc("status", OFF_IRQ_STATUS, 32'h0);
        $display("index test done");
    endtask : t_index
    task automatic t_hold;
        qec_enc_model_inst.step(0, 2);
        // wait out a capture period so position holds a nonzero value first
        repeat (170) @(posedge sys_clk);
        rc("position", 8'h34, 32'h200);
        wr(8'h20, 32'ha);
        rc("count", 8'h2c, 32'h0);
        rc("position", 8'h34, 32'h0);
        qec_enc_model_inst.step(0, 2);
        rc("count", 8'h2c, 32'h0);
        rc("raw", 8'h30, 32'h8);
        wr(8'h20, 32'h2);
        qec_enc_model_inst.step(0, 3);
        rc("count", 8'h2c, 32'h3);
        $display("count reset test done");
    endtask : t_hold
    task automatic t_scale;
        wrd(8'h24, 32'h2, 8'h24);
        chk("scale", 32'h2, q);
        qec_enc_model_inst.step(0, 20);
        // four to eight counts fall in one capture period at this step rate
        wrd(8'h28, 32'h0, 8'h38);
        checks_done++;
        if ((q >= 32'h200 && q <= 32'h400) !== 1'b1) begin
            errors++;
            $display("wrong value velocity expected 200 to 400 seen %h", q);
        end
        wr(8'h28, 32'hffff);
        qec_enc_model_inst.step(0, 20);
        rc("velocity", 8'h38, 32'h0);
        // one full capture period after the last count
        repeat (170) @(posedge sys_clk);
        rc("position", 8'h34, 32'h1580);
        rc("interp", 8'h3c, 32'h1580);
        $display("scaling test done");
    endtask : t_scale
    initial begin
        reset = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_modes();
        t_index();
        t_hold();
        t_scale();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end
endmodule : tb
